// ===== core/fropb_regs.svh
`ifndef FROPB_REGS_SVH
`define FROPB_REGS_SVH

// Instruction word fields (12-bit word)
`define FROPB_FADDR_LSB     0
`define FROPB_FADDR_MSB     4
`define FROPB_DEST_BIT      5
`define FROPB_OPC_LSB       6
`define FROPB_OPC_MSB       11
`define FROPB_BRANCH_LSB    0
`define FROPB_BRANCH_MSB    8
`define FROPB_BROPC_LSB     9
`define FROPB_BROPC_MSB     11

// Opcodes, upper six bits of the word; branch opcode is the upper three bits
`define FROPB_OPC_CLEAR     6'h01
`define FROPB_OPC_DEC       6'h03
`define FROPB_OPC_COMP      6'h09
`define FROPB_OPC_INC       6'h0A
`define FROPB_OPC_DECSKIP   6'h0B
`define FROPB_OPC_INCSKIP   6'h0F
`define FROPB_OPC_BRANCH    3'h5
`define FROPB_CLEAR_D       1'h1

// Status register bit positions
`define FROPB_STAT_Z        2
`define FROPB_STAT_PAGE_LSB 5
`define FROPB_STAT_PAGE_MSB 6

// Reset values
`define FROPB_W_RESET       8'h00
`define FROPB_STAT_RESET    8'h18
`define FROPB_PC_RESET      11'h7FF
`define FROPB_ZERO_BYTE     8'h00
`define FROPB_STATUS_ADDR   5'h03

`endif

// ===== core/fropb_pkg.sv
package fropb_pkg;
  typedef enum logic [2:0] {
    FROPB_NONE,
    FROPB_CLR,
    FROPB_COM,
    FROPB_DEC,
    FROPB_INC,
    FROPB_DECSZ,
    FROPB_INCSZ,
    FROPB_BRA
  } fropb_op_t;

  typedef enum logic [1:0] {
    FROPB_RUN,
    FROPB_FLUSH
  } fropb_state_t;
endpackage

// ===== core/fropb_alu.sv
`timescale 1ns/1ps
`include "fropb_regs.svh"

module fropb_alu
  import fropb_pkg::*;
(
  // Operation and operand
  input  wire fropb_op_t  op,
  input  wire logic [7:0] operand,
  // Result
  output logic [7:0]      result,
  output logic            is_zero,
  output logic            sets_z
);

  always_comb begin
    result = operand;
    sets_z = 1'b0;
    case (op)
      FROPB_CLR: begin
        result = `FROPB_ZERO_BYTE;
        sets_z = 1'b1;
      end
      FROPB_COM: begin
        result = ~operand;
        sets_z = 1'b1;
      end
      FROPB_DEC, FROPB_DECSZ: begin
        result = operand - 8'h01;
        sets_z = (op == FROPB_DEC);
      end
      FROPB_INC, FROPB_INCSZ: begin
        result = operand + 8'h01;
        sets_z = (op == FROPB_INC);
      end
      default: begin
        result = operand;
        sets_z = 1'b0;
      end
    endcase
    is_zero = (result == `FROPB_ZERO_BYTE);
  end

endmodule

// ===== core/fropb_core.sv
`timescale 1ns/1ps
`include "fropb_regs.svh"

// Behaviour
// - clear_file_op writes zero to the file register and sets zero flag.
// - complement_file_op result is bitwise inversion of file register.
// - Destination bit 0 writes working register, 1 writes file; address 0..31.
// - decrement_file_op subtracts one and writes selected destination.
// - increment_file_op adds one and writes selected destination.
// - decrement_skip_zero_op with zero result flushes next instruction, two cycles.
// - increment_skip_zero_op zero result flushes next; skip variants leave flags.
// - branch_op loads its 9-bit operand into program counter bits 8:0.
// - branch_op fills program counter bits 10:9 from status bits 6:5.
// - branch_op takes two instruction cycles.
module fropb_core
  import fropb_pkg::*;
#(
  parameter int FILE_DEPTH = 32,
  parameter int PC_WIDTH   = 11
)(
  // Clock and reset
  input  wire logic                clk,
  input  wire logic                rst,
  input  wire logic                ce,
  // Instruction fetch
  input  wire logic [11:0]         instr,
  output logic      [PC_WIDTH-1:0] pc,
  // Visible state
  output logic      [7:0]          w_reg,
  output logic      [7:0]          status_reg,
  output logic                     flush_busy
);

  // Decode and reset values assume the 32-entry, 11-bit layout
  if (FILE_DEPTH != 32 || PC_WIDTH != 11) begin : gen_bad_params
    $error("fropb_core: FILE_DEPTH must be 32 and PC_WIDTH 11");
  end

  logic [7:0]          file_r   [FILE_DEPTH];
  logic [7:0]          file_nxt [FILE_DEPTH];
  logic [7:0]          w_r, w_nxt;
  logic [7:0]          stat_r, stat_nxt;
  logic [PC_WIDTH-1:0] pc_r, pc_nxt;
  fropb_state_t        st_r, st_nxt;

  fropb_op_t   op;
  logic [4:0]  faddr;
  logic        dest;
  logic [7:0]  operand;
  logic [7:0]  result;
  logic        is_zero;
  logic        sets_z;

  function automatic fropb_op_t decode(input logic [11:0] word);
    logic [5:0] opc;
    opc = word[`FROPB_OPC_MSB:`FROPB_OPC_LSB];
    if (word[`FROPB_BROPC_MSB:`FROPB_BROPC_LSB] == `FROPB_OPC_BRANCH)
      return FROPB_BRA;
    else if (opc == `FROPB_OPC_CLEAR && word[`FROPB_DEST_BIT] == `FROPB_CLEAR_D)
      return FROPB_CLR;
    else if (opc == `FROPB_OPC_COMP)
      return FROPB_COM;
    else if (opc == `FROPB_OPC_DEC)
      return FROPB_DEC;
    else if (opc == `FROPB_OPC_INC)
      return FROPB_INC;
    else if (opc == `FROPB_OPC_DECSKIP)
      return FROPB_DECSZ;
    else if (opc == `FROPB_OPC_INCSKIP)
      return FROPB_INCSZ;
    else
      return FROPB_NONE;
  endfunction

  always_comb begin
    op      = (st_r == FROPB_FLUSH) ? FROPB_NONE : decode(instr);
    faddr   = instr[`FROPB_FADDR_MSB:`FROPB_FADDR_LSB];
    dest    = instr[`FROPB_DEST_BIT];
    operand = (faddr == `FROPB_STATUS_ADDR) ? stat_r : file_r[faddr];
  end

  fropb_alu u_alu (
    .op      (op),
    .operand (operand),
    .result  (result),
    .is_zero (is_zero),
    .sets_z  (sets_z)
  );

  always_comb begin
    file_nxt = file_r;
    w_nxt    = w_r;
    stat_nxt = stat_r;
    pc_nxt   = pc_r + 11'h001;
    st_nxt   = FROPB_RUN;
    case (op)
      FROPB_NONE: begin
        w_nxt = w_r;
      end
      FROPB_BRA: begin
        // Pipeline refill makes the branch two cycles
        pc_nxt = {stat_r[`FROPB_STAT_PAGE_MSB:`FROPB_STAT_PAGE_LSB],
                  instr[`FROPB_BRANCH_MSB:`FROPB_BRANCH_LSB]};
        st_nxt = FROPB_FLUSH;
      end
      default: begin
        if (op == FROPB_CLR || dest) begin
          if (faddr == `FROPB_STATUS_ADDR)
            stat_nxt = result;
          else
            file_nxt[faddr] = result;
        end else begin
          w_nxt = result;
        end
        // Flag update wins over a result written to status
        if (sets_z)
          stat_nxt[`FROPB_STAT_Z] = is_zero;
        if ((op == FROPB_DECSZ || op == FROPB_INCSZ) && is_zero)
          st_nxt = FROPB_FLUSH;
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < FILE_DEPTH; i++) begin
        file_r[i] <= `FROPB_ZERO_BYTE;
      end
      w_r    <= `FROPB_W_RESET;
      stat_r <= `FROPB_STAT_RESET;
      pc_r   <= `FROPB_PC_RESET;
      st_r   <= FROPB_RUN;
    end else if (ce) begin
      file_r <= file_nxt;
      w_r    <= w_nxt;
      stat_r <= stat_nxt;
      pc_r   <= pc_nxt;
      st_r   <= st_nxt;
    end
  end

  assign pc         = pc_r;
  assign w_reg      = w_r;
  assign status_reg = stat_r;
  assign flush_busy = (st_r == FROPB_FLUSH);

  chk_clear_sets_z: assert property (@(posedge clk) disable iff (rst)
    (ce && op == FROPB_CLR && faddr != `FROPB_STATUS_ADDR) |=>
      (stat_r[`FROPB_STAT_Z] && file_r[$past(faddr)] == `FROPB_ZERO_BYTE))
    else $error("clear did not zero register and set flag");

  chk_comp_to_w: assert property (@(posedge clk) disable iff (rst)
    (ce && op == FROPB_COM && !dest) |=> (w_r == ~$past(operand)))
    else $error("complement result wrong");

  chk_dest_file: assert property (@(posedge clk) disable iff (rst)
    (ce && op == FROPB_INC && dest && faddr != `FROPB_STATUS_ADDR) |=>
      (w_r == $past(w_r)))
    else $error("working register changed for file destination");

  chk_dec_value: assert property (@(posedge clk) disable iff (rst)
    (ce && op == FROPB_DEC && !dest) |=> (w_r == $past(operand) - 8'h01))
    else $error("decrement result wrong");

  chk_inc_value: assert property (@(posedge clk) disable iff (rst)
    (ce && op == FROPB_INC && !dest) |=> (w_r == $past(operand) + 8'h01))
    else $error("increment result wrong");

  chk_skip_flush: assert property (@(posedge clk) disable iff (rst)
    (ce && op == FROPB_DECSZ && operand == 8'h01) |=> (flush_busy && pc == $past(pc) + 11'h001))
    else $error("decrement skip did not discard next instruction");

  chk_skip_flags: assert property (@(posedge clk) disable iff (rst)
    (ce && (op == FROPB_INCSZ || op == FROPB_DECSZ) && faddr != `FROPB_STATUS_ADDR)
      |=> (stat_r == $past(stat_r)))
    else $error("skip variant changed status");

  chk_branch_pc: assert property (@(posedge clk) disable iff (rst)
    (ce && op == FROPB_BRA) |=> (pc[8:0] == $past(instr[8:0])))
    else $error("branch low address wrong");

  chk_branch_page: assert property (@(posedge clk) disable iff (rst)
    (ce && op == FROPB_BRA) |=> (pc[10:9] == $past(stat_r[6:5])))
    else $error("branch page bits wrong");

  chk_branch_cycles: assert property (@(posedge clk) disable iff (rst)
    (ce && op == FROPB_BRA) |=> (flush_busy && op == FROPB_NONE))
    else $error("branch not two cycles");

  chk_flush_single: assert property (@(posedge clk) disable iff (rst)
    (ce && flush_busy) |=> !flush_busy)
    else $error("flush lasted more than one enabled cycle");

  chk_incskip_flush: assert property (@(posedge clk) disable iff (rst)
    (ce && op == FROPB_INCSZ && operand == 8'hFF) |=> (flush_busy && pc == $past(pc) + 11'h001))
    else $error("increment skip did not discard next instruction");

  chk_comp_file: assert property (@(posedge clk) disable iff (rst)
    (ce && op == FROPB_COM && dest && faddr != `FROPB_STATUS_ADDR) |=>
      (file_r[$past(faddr)] == ~$past(operand)))
    else $error("complement not written back to file register");

  chk_dec_zero: assert property (@(posedge clk) disable iff (rst)
    (ce && op == FROPB_DEC && faddr != `FROPB_STATUS_ADDR) |=>
      (stat_r[`FROPB_STAT_Z] == ($past(operand) == 8'h01)))
    else $error("zero flag wrong after decrement");

  chk_comp_zero: assert property (@(posedge clk) disable iff (rst)
    (ce && op == FROPB_COM && faddr != `FROPB_STATUS_ADDR) |=>
      (stat_r[`FROPB_STAT_Z] == ($past(operand) == 8'hFF)))
    else $error("zero flag wrong after complement");

  chk_inc_zero: assert property (@(posedge clk) disable iff (rst)
    (ce && op == FROPB_INC && faddr != `FROPB_STATUS_ADDR) |=>
      (stat_r[`FROPB_STAT_Z] == ($past(operand) == 8'hFF)))
    else $error("zero flag wrong after increment");

endmodule

// ===== testbench/file_register_ops_and_branch_tb.sv
`timescale 1ns/1ps
`define CMP(nm, exp, got) begin checks++; if ((got) !== (exp)) begin bad_count++; \
  $display("[FAIL] %s expected %h seen %h", nm, exp, got); end end

module file_register_ops_and_branch_tb;
  logic        clk;
  logic        rst;
  logic        ce;
  logic [11:0] instr;
  logic [10:0] pc;
  logic [7:0]  w_reg;
  logic [7:0]  status_reg;
  logic        flush_busy;
  logic [7:0]  m_file [32];
  logic [7:0]  m_w;
  logic [10:0] m_pc;
  logic        m_flush;
  integer      seed;
  int          bad_count;
  int          checks;

  fropb_core #(.FILE_DEPTH(32), .PC_WIDTH(11)) dut_u (
    .clk        (clk),
    .rst        (rst),
    .ce         (ce),
    .instr      (instr),
    .pc         (pc),
    .w_reg      (w_reg),
    .status_reg (status_reg),
    .flush_busy (flush_busy)
  );

  initial clk = 1'b0;
  always #50 clk = ~clk;

  // Reference model; address 3 doubles as status, so page bits follow writes
  task automatic model(input logic [11:0] i, input logic e);
    logic [7:0] r;
    logic       skip;
    logic [4:0] a;
    if (!e) return;
    a = i[4:0];
    skip = 1'b0;
    m_pc = m_pc + 11'h001;
    if (m_flush) begin
      m_flush = 1'b0;
      return;
    end
    if (i[11:9] == 3'h5) begin
      m_pc = {m_file[3][6:5], i[8:0]};
      m_flush = 1'b1;
      return;
    end
    case (i[11:6])
      6'h01: r = 8'h00;
      6'h09: r = ~m_file[a];
      6'h03: r = m_file[a] - 8'h01;
      6'h0A: r = m_file[a] + 8'h01;
      6'h0B: begin r = m_file[a] - 8'h01; skip = 1'b1; end
      6'h0F: begin r = m_file[a] + 8'h01; skip = 1'b1; end
      default: return;
    endcase
    if (i[5]) m_file[a] = r;
    else m_w = r;
    if (!skip) m_file[3][2] = (r == 8'h00);
    else if (r == 8'h00) m_flush = 1'b1;
  endtask

  // Outputs after an edge reflect the word driven one step earlier
  task automatic step(input logic [11:0] i, input logic e);
    @(posedge clk);
    instr <= i;
    ce    <= e;
    #1;
    `CMP("pc", m_pc, pc)
    `CMP("w_reg", m_w, w_reg)
    `CMP("status_reg", m_file[3], status_reg)
    `CMP("flush_busy", m_flush, flush_busy)
    model(i, e);
  endtask

  // Clear only exists with destination set, so force it there
  function automatic logic [11:0] pick(input logic [31:0] v);
    logic [5:0] opc;
    case (v[2:0])
      3'h0: opc = 6'h01;
      3'h1: opc = 6'h09;
      3'h2: opc = 6'h03;
      3'h3: opc = 6'h0A;
      3'h4: opc = 6'h0B;
      3'h5: opc = 6'h0F;
      3'h6: return {3'h5, v[16:8]};
      default: return 12'h000;
    endcase
    return {opc, v[3] | (v[2:0] == 3'h0), v[8:4]};
  endfunction

  task automatic summarize;
    $display("checks=%0d bad_count=%0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  initial begin
    #200000;
    bad_count++;
    summarize();
  end

  initial begin
    seed = 32'h27E997B5;
    bad_count = 0;
    checks = 0;
    rst = 1'b1;
    ce = 1'b0;
    instr = 12'h000;
    foreach (m_file[k]) m_file[k] = 8'h00;
    m_file[3] = 8'h18;
    m_w = 8'h00;
    m_pc = 11'h7FF;
    m_flush = 1'b0;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    step(12'h067, 1'b1);
    step(12'h2E7, 1'b1);
    step(12'h3C7, 1'b1);
    step(12'hBFF, 1'b1);
    step(12'h3E7, 1'b1);
    step(12'h3E7, 1'b0);
    step(12'h0E7, 1'b1);
    step(12'h263, 1'b1);
    step(12'hBFF, 1'b1);
    step(12'h000, 1'b1);
    step(12'h2C7, 1'b1);
    step(12'h2A7, 1'b1);
    step(12'h2E7, 1'b1);
    step(12'h2A7, 1'b1);
    repeat (1500) step(pick($random(seed)), ($random(seed) & 7) != 0);
    step(12'h000, 1'b1);
    step(12'h000, 1'b1);
    summarize();
  end
endmodule
